// [logic/mac_ctrl_pkg.sv]
// Package: register map, field positions and timing for the MAC control core
package mac_ctrl_pkg;
  localparam int          ClkHz           = 50000000;
  localparam int          SoftResetUs     = 10;
  localparam int          SoftResetCycles = (ClkHz / 1000000) * SoftResetUs;
  localparam logic [3:0]  AdrNetCtrl      = 4'h0;
  localparam logic [3:0]  AdrNetStat      = 4'h1;
  localparam logic [3:0]  AdrTxCtrl       = 4'h2;
  localparam logic [3:0]  AdrIrqStat      = 4'h3;
  localparam logic [3:0]  AdrIrqMask      = 4'h4;
  localparam logic [7:0]  ResetByte       = 8'h00;
  localparam logic [31:0] ResetWord       = 32'h00000000;
  localparam logic [1:0]  LoopNormal      = 2'h0;
  localparam logic [1:0]  LoopMac         = 2'h1;
  localparam logic [1:0]  LoopPhy         = 2'h2;
  // Network control bits
  localparam int NcWake  = 6;
  localparam int NcFcol  = 4;
  localparam int NcFdx   = 3;
  localparam int NcLbkHi = 2;
  localparam int NcLbkLo = 1;
  localparam int NcRst   = 0;
  // Network status bits
  localparam int NsSpeed = 7;
  localparam int NsLink  = 6;
  localparam int NsWake  = 5;
  localparam int NsTx2   = 3;
  localparam int NsTx1   = 2;
  localparam int NsRxov  = 1;
  // Transmit control bits
  localparam int TcJab   = 6;
  localparam int TcExc   = 5;
  localparam int TcPad2  = 4;
  localparam int TcCrc2  = 3;
  localparam int TcPad1  = 2;
  localparam int TcCrc1  = 1;
  localparam int TcReq   = 0;
  // Interrupt status / mask bits
  localparam int IrqWake = 0;
  localparam int IrqTx1  = 1;
  localparam int IrqTx2  = 2;
  localparam int IrqRxov = 3;
  localparam int IrqBits = 4;

  typedef struct packed {
    logic jabberTimerDisable;
    logic excessCollisionRetry;
    logic padDisableIndex2;
    logic crcDisableIndex2;
    logic padDisableIndex1;
    logic crcDisableIndex1;
  } tx_cfg_t;

  typedef struct packed {
    logic phySpeed10;
    logic linkGood;
    logic duplexFull;
    logic wakeupEvent;
    logic index1Done;
    logic index2Done;
    logic rxOverflow;
  } dp_status_t;
endpackage

// [logic/mac_network_tx_control.sv]
// Network control, network status and transmit control registers on Wishbone
// Notes on behaviour
// - Control bit 6 enables wakeup; writing zero clears latched wakeup events.
// - Wakeup enable survives software reset; power-on reset or writing zero to bit 6 clears it.
// - Control bit 4 forces collisions for test; cleared by either reset.
// - Control bit 3 reads PHY duplex: one full, zero half.
// - Bits 2:1 select loopback: normal, MAC internal, PHY digital; 11 reserved.
// - Writing one to control bit 0 resets; bit clears itself after 10us.
// - Status bit 7 shows PHY speed: zero 100M, one 10M.
// - Status bit 6 reads one while PHY link is good.
// - Status bit 5 latches wakeup; read or write-one clears; survives software reset.
// - Status bit 3 sets when index 2 send completes; read or write-one clears.
// - Status bit 2 sets when index 1 send completes; read or write-one clears.
// - Status bit 1 shows receive FIFO overflow; cleared by either reset.
// - Transmit bit 6 set disables the 2048-byte jabber timer.
// - Transmit bit 5 selects retry forever versus abandon after 15 collisions.
// - Transmit bits 4 and 3 suppress pad and CRC for index 2.
// - Transmit bits 2 and 1 suppress pad and CRC for index 1.
// - Host sets transmit bit 0; device holds it until packet fully sent.
// - Registers take defaults on any reset except fields spared by software reset.
//
// Chosen here: the Wishbone slave port.
module mac_network_tx_control (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      wbCycI,
  input  wire logic                      wbStbI,
  input  wire logic                      wbWeI,
  input  wire logic [3:0]                wbSelI,
  input  wire logic [31:0]               wbAdrI,
  input  wire logic [31:0]               wbDatI,
  output logic      [31:0]               wbDatO,
  output logic                           wbAckO,
  input  wire logic                      phyDuplexFull,
  input  wire logic                      phySpeed10,
  input  wire logic                      phyLinkGood,
  input  wire logic                      wakeupEventIn,
  input  wire logic                      index1SendDone,
  input  wire logic                      index2SendDone,
  input  wire logic                      rxFifoOverflow,
  output logic                           wakeupEnable,
  output logic                           forcedCollisionTest,
  output logic      [1:0]                loopbackSelect,
  output logic                           softResetActive,
  output mac_ctrl_pkg::tx_cfg_t          txConfig,
  output logic                           transmitRequest,
  output logic                           irq
);

  typedef enum logic [1:0] {
    BusIdle = 2'b01,
    BusAck  = 2'b10
  } bus_state_t;

  bus_state_t               busState;
  mac_ctrl_pkg::dp_status_t dpSync1;
  mac_ctrl_pkg::dp_status_t dpSync2;
  logic                     wakeSeen;
  logic                     tx1Seen;
  logic                     tx2Seen;
  logic                     overflowSeen;
  logic                     wakeupEventFlag;
  logic                     index1Done;
  logic                     index2Done;
  logic [15:0]              resetCount;
  logic [mac_ctrl_pkg::IrqBits-1:0] irqStatus;
  logic [mac_ctrl_pkg::IrqBits-1:0] irqMask;
  logic [mac_ctrl_pkg::IrqBits-1:0] irqEvents;
  logic                     wakeRise;
  logic                     tx1Rise;
  logic                     tx2Rise;
  logic                     ovRise;
  logic                     anyReset;
  logic                     request;
  logic                     writeReq;
  logic                     readReq;
  logic [3:0]               regIndex;
  logic [7:0]               wrByte;

  // Register index match; writes also need byte lane zero, which writeReq supplies
  function automatic logic hit(input logic [3:0] idx, input logic [3:0] want);
    hit = (idx == want);
  endfunction

  // Status pins come from other logic clock trees, so two flops first
  always_ff @(posedge clk) begin
    if (reset) begin
      dpSync1 <= '0;
      dpSync2 <= '0;
    end else begin
      dpSync1 <= '{phySpeed10, phyLinkGood, phyDuplexFull, wakeupEventIn,
                   index1SendDone, index2SendDone, rxFifoOverflow};
      dpSync2 <= dpSync1;
    end
  end

  // Previous samples for edge detection, taken from the second stage only
  always_ff @(posedge clk) begin
    if (reset) begin
      wakeSeen     <= 1'b0;
      tx1Seen      <= 1'b0;
      tx2Seen      <= 1'b0;
      overflowSeen <= 1'b0;
    end else begin
      wakeSeen     <= dpSync2.wakeupEvent;
      tx1Seen      <= dpSync2.index1Done;
      tx2Seen      <= dpSync2.index2Done;
      overflowSeen <= dpSync2.rxOverflow;
    end
  end

  assign wakeRise = dpSync2.wakeupEvent & ~wakeSeen & wakeupEnable;
  assign tx1Rise  = dpSync2.index1Done & ~tx1Seen;
  assign tx2Rise  = dpSync2.index2Done & ~tx2Seen;
  assign ovRise   = dpSync2.rxOverflow & ~overflowSeen;

  assign anyReset = reset | softResetActive;
  assign request  = wbCycI & wbStbI & (busState == BusIdle);
  assign writeReq = request & wbWeI & wbSelI[0];
  assign readReq  = request & ~wbWeI;
  assign regIndex = wbAdrI[5:2];
  assign wrByte   = wbDatI[7:0];

  // Classic single-cycle slave: ack one cycle after strobe, then one idle
  always_ff @(posedge clk) begin
    if (reset) begin
      busState <= BusIdle;
      wbAckO   <= 1'b0;
    end else begin
      case (busState)
        BusIdle: begin
          if (wbCycI && wbStbI) begin
            busState <= BusAck;
            wbAckO   <= 1'b1;
          end
        end
        BusAck: begin
          busState <= BusIdle;
          wbAckO   <= 1'b0;
        end
        default: begin
          busState <= BusIdle;
          wbAckO   <= 1'b0;
        end
      endcase
    end
  end

  // Read data; unmapped offsets and reserved bits read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      wbDatO <= mac_ctrl_pkg::ResetWord;
    end else if (readReq) begin
      wbDatO <= mac_ctrl_pkg::ResetWord;
      case (regIndex)
        mac_ctrl_pkg::AdrNetCtrl: begin
          wbDatO[mac_ctrl_pkg::NcWake]  <= wakeupEnable;
          wbDatO[mac_ctrl_pkg::NcFcol]  <= forcedCollisionTest;
          wbDatO[mac_ctrl_pkg::NcFdx]   <= dpSync2.duplexFull;
          wbDatO[mac_ctrl_pkg::NcLbkHi:mac_ctrl_pkg::NcLbkLo] <= loopbackSelect;
          wbDatO[mac_ctrl_pkg::NcRst]   <= softResetActive;
        end
        mac_ctrl_pkg::AdrNetStat: begin
          wbDatO[mac_ctrl_pkg::NsSpeed] <= dpSync2.phySpeed10;
          wbDatO[mac_ctrl_pkg::NsLink]  <= dpSync2.linkGood;
          wbDatO[mac_ctrl_pkg::NsWake]  <= wakeupEventFlag;
          wbDatO[mac_ctrl_pkg::NsTx2]   <= index2Done;
          wbDatO[mac_ctrl_pkg::NsTx1]   <= index1Done;
          wbDatO[mac_ctrl_pkg::NsRxov]  <= dpSync2.rxOverflow & ~softResetActive;
        end
        mac_ctrl_pkg::AdrTxCtrl: begin
          wbDatO[mac_ctrl_pkg::TcJab:mac_ctrl_pkg::TcCrc1] <= txConfig;
          wbDatO[mac_ctrl_pkg::TcReq]   <= transmitRequest;
        end
        mac_ctrl_pkg::AdrIrqStat: wbDatO[mac_ctrl_pkg::IrqBits-1:0] <= irqStatus;
        mac_ctrl_pkg::AdrIrqMask: wbDatO[mac_ctrl_pkg::IrqBits-1:0] <= irqMask;
        default: wbDatO <= mac_ctrl_pkg::ResetWord;
      endcase
    end
  end

  // Wakeup enable cleared by power-on reset or a control write of zero
  always_ff @(posedge clk) begin
    if (reset) begin
      wakeupEnable <= 1'b0;
    end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrNetCtrl)) begin
      wakeupEnable <= wrByte[mac_ctrl_pkg::NcWake];
    end
  end

  // Test and loopback controls follow either reset
  always_ff @(posedge clk) begin
    if (anyReset) begin
      forcedCollisionTest <= 1'b0;
      loopbackSelect      <= mac_ctrl_pkg::LoopNormal;
    end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrNetCtrl)) begin
      forcedCollisionTest <= wrByte[mac_ctrl_pkg::NcFcol];
      loopbackSelect      <= wrByte[mac_ctrl_pkg::NcLbkHi:mac_ctrl_pkg::NcLbkLo];
    end
  end

  // Software reset pulse with its own timer; bus stays usable meanwhile
  always_ff @(posedge clk) begin
    if (reset) begin
      softResetActive <= 1'b0;
      resetCount      <= 16'h0000;
    end else if (softResetActive) begin
      if (resetCount == 16'(mac_ctrl_pkg::SoftResetCycles - 1)) begin
        softResetActive <= 1'b0;
        resetCount      <= 16'h0000;
      end else begin
        resetCount <= resetCount + 16'h0001;
      end
    end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrNetCtrl) &&
                 wrByte[mac_ctrl_pkg::NcRst]) begin
      softResetActive <= 1'b1;
    end
  end

  // Wakeup flag: set beats clear, untouched by software reset
  always_ff @(posedge clk) begin
    if (reset) begin
      wakeupEventFlag <= 1'b0;
    end else if (wakeRise) begin
      wakeupEventFlag <= 1'b1;
    end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrNetCtrl) &&
                 !wrByte[mac_ctrl_pkg::NcWake]) begin
      wakeupEventFlag <= 1'b0;
    end else if ((readReq && hit(regIndex, mac_ctrl_pkg::AdrNetStat)) ||
                 (writeReq && hit(regIndex, mac_ctrl_pkg::AdrNetStat) &&
                  wrByte[mac_ctrl_pkg::NsWake])) begin
      wakeupEventFlag <= 1'b0;
    end
  end

  // Completion flags for both packet indexes
  always_ff @(posedge clk) begin
    if (anyReset) begin
      index1Done <= 1'b0;
      index2Done <= 1'b0;
    end else begin
      if (tx1Rise) begin
        index1Done <= 1'b1;
      end else if ((readReq && hit(regIndex, mac_ctrl_pkg::AdrNetStat)) ||
                   (writeReq && hit(regIndex, mac_ctrl_pkg::AdrNetStat) &&
                    wrByte[mac_ctrl_pkg::NsTx1])) begin
        index1Done <= 1'b0;
      end
      if (tx2Rise) begin
        index2Done <= 1'b1;
      end else if ((readReq && hit(regIndex, mac_ctrl_pkg::AdrNetStat)) ||
                   (writeReq && hit(regIndex, mac_ctrl_pkg::AdrNetStat) &&
                    wrByte[mac_ctrl_pkg::NsTx2])) begin
        index2Done <= 1'b0;
      end
    end
  end

  // Transmit configuration, driven straight to the datapath
  always_ff @(posedge clk) begin
    if (anyReset) begin
      txConfig <= '0;
    end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrTxCtrl)) begin
      txConfig.jabberTimerDisable   <= wrByte[mac_ctrl_pkg::TcJab];
      txConfig.excessCollisionRetry <= wrByte[mac_ctrl_pkg::TcExc];
      txConfig.padDisableIndex2     <= wrByte[mac_ctrl_pkg::TcPad2];
      txConfig.crcDisableIndex2     <= wrByte[mac_ctrl_pkg::TcCrc2];
      txConfig.padDisableIndex1     <= wrByte[mac_ctrl_pkg::TcPad1];
      txConfig.crcDisableIndex1     <= wrByte[mac_ctrl_pkg::TcCrc1];
    end
  end

  // Request held until a completion; writing zero cannot cancel a send
  always_ff @(posedge clk) begin
    if (anyReset) begin
      transmitRequest <= 1'b0;
    end else if (tx1Rise || tx2Rise) begin
      transmitRequest <= 1'b0;
    end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrTxCtrl) &&
                 wrByte[mac_ctrl_pkg::TcReq]) begin
      transmitRequest <= 1'b1;
    end
  end

  assign irqEvents = {ovRise, tx2Rise, tx1Rise, wakeRise};

  // Sticky interrupt status, write one to clear, set wins
  generate
    for (genvar i = 0; i < mac_ctrl_pkg::IrqBits; i++) begin : gIrq
      always_ff @(posedge clk) begin
        if (reset) begin
          irqStatus[i] <= 1'b0;
        end else if (irqEvents[i]) begin
          irqStatus[i] <= 1'b1;
        end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrIrqStat) && wrByte[i]) begin
          irqStatus[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      irqMask <= '0;
    end else if (writeReq && hit(regIndex, mac_ctrl_pkg::AdrIrqMask)) begin
      irqMask <= wrByte[mac_ctrl_pkg::IrqBits-1:0];
    end
  end

  // Registered, so irq lags a status change by one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

endmodule // mac_network_tx_control

// [bench/mac_ctrl_assertions.sv]
// Checker for the MAC control core, bound to its top module
module mac_ctrl_assertions (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  wbCycI,
  input wire logic                  wbStbI,
  input wire logic                  wbWeI,
  input wire logic [31:0]           wbAdrI,
  input wire logic [31:0]           wbDatO,
  input wire logic                  wbAckO,
  input wire logic                  index1SendDone,
  input wire logic                  index2SendDone,
  input wire logic                  wakeupEnable,
  input wire logic                  forcedCollisionTest,
  input wire logic [1:0]            loopbackSelect,
  input wire logic                  softResetActive,
  input wire mac_ctrl_pkg::tx_cfg_t txConfig,
  input wire logic                  transmitRequest,
  input wire logic                  irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  int unsigned rstLen;
  logic        take;
  assign take = wbCycI && wbStbI && !wbAckO;
  // Counts sampled cycles of software reset
  always_ff @(posedge clk) begin
    rstLen <= (softResetActive && !reset) ? rstLen + 1 : 0;
  end
  a_ack_after_take: assert property (take |=> wbAckO) else $error("request not acknowledged");
  a_ack_single: assert property (wbAckO |=> !wbAckO) else $error("ack held too long");
  a_read_upper_zero: assert property (wbAckO && !wbWeI |-> wbDatO[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_swreset_length: assert property ($fell(softResetActive) |->
    rstLen == mac_ctrl_pkg::SoftResetCycles) else $error("software reset length wrong");
  a_swreset_clears: assert property (softResetActive && $past(softResetActive) |->
    !forcedCollisionTest && loopbackSelect == 2'h0 && txConfig == '0 && !transmitRequest)
    else $error("software reset left control fields set");
  a_wake_kept: assert property (softResetActive && $past(softResetActive) |->
    $stable(wakeupEnable)) else $error("wakeup enable moved in software reset");
  a_wake_clear_cause: assert property ($fell(wakeupEnable) |->
    $past(take && wbWeI && wbAdrI[5:2] == mac_ctrl_pkg::AdrNetCtrl))
    else $error("wakeup enable cleared without a write");
  a_req_clear_cause: assert property ($fell(transmitRequest) |-> softResetActive ||
    $past(index1SendDone || index2SendDone, 2) || $past(index1SendDone || index2SendDone, 3) ||
    $past(index1SendDone || index2SendDone, 4)) else $error("request dropped before completion");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=>
    !wbAckO && !irq && !softResetActive && !wakeupEnable) else $error("outputs set after reset");
  c_soft_reset: cover property ($fell(softResetActive));
  c_irq: cover property ($rose(irq));
  c_tx_done: cover property ($fell(transmitRequest));
endmodule // mac_ctrl_assertions

bind mac_network_tx_control mac_ctrl_assertions i_mac_ctrl_assertions (.clk, .reset, .wbCycI,
  .wbStbI, .wbWeI, .wbAdrI, .wbDatO, .wbAckO, .index1SendDone, .index2SendDone, .wakeupEnable,
  .forcedCollisionTest, .loopbackSelect, .softResetActive, .txConfig, .transmitRequest, .irq);

// [bench/tx_datapath_model.sv]
// Behavioural transmit datapath that answers requests with completion pulses
module tx_datapath_model (
  input  wire logic       clk,
  input  wire logic       transmitRequest,
  input  wire logic [3:0] lag,
  output logic            index1SendDone,
  output logic            index2SendDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic useIndex2 = 1'b0;
  initial begin
    index1SendDone = 1'b0;
    index2SendDone = 1'b0;
  end
  // Packets alternate between the two indices; lag makes it prompt or slow
  always begin
    @(posedge clk iff transmitRequest === 1'b1);
    repeat (lag + 4) @(posedge clk);
    if (useIndex2) index2SendDone <= 1'b1;
    else index1SendDone <= 1'b1;
    repeat (2) @(posedge clk);
    index1SendDone <= 1'b0;
    index2SendDone <= 1'b0;
    useIndex2 <= !useIndex2;
    wait (transmitRequest !== 1'b1);
    @(posedge clk);
  end
endmodule // tx_datapath_model

// [bench/mac_network_tx_control_tb.sv]
// Self-checking bench for the MAC network and transmit control registers
module mac_network_tx_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, wbCycI = 1'b0, wbStbI = 1'b0, wbWeI = 1'b0, wbAckO, irq;
  logic [3:0] wbSelI = 4'h0, lag = 4'h0;
  logic [31:0] wbAdrI = 32'h0, wbDatI = 32'h0, wbDatO, lfsr = 32'h69BA281B;
  logic phyDuplexFull = 1'b0, phySpeed10 = 1'b0, phyLinkGood = 1'b0, rxFifoOverflow = 1'b0;
  logic wakeupEventIn = 1'b0, index1SendDone, index2SendDone, wakeupEnable;
  logic forcedCollisionTest, softResetActive, transmitRequest;
  logic [1:0] loopbackSelect;
  mac_ctrl_pkg::tx_cfg_t txConfig;
  logic [63:0] expQ[$];
  logic [63:0] ent;
  int errors = 0, check_count = 0;
  always #10 clk = ~clk;
  mac_network_tx_control i_mac_network_tx_control (.clk, .reset, .wbCycI, .wbStbI, .wbWeI,
    .wbSelI, .wbAdrI, .wbDatI, .wbDatO, .wbAckO, .phyDuplexFull, .phySpeed10, .phyLinkGood,
    .wakeupEventIn, .index1SendDone, .index2SendDone, .rxFifoOverflow, .wakeupEnable,
    .forcedCollisionTest, .loopbackSelect, .softResetActive, .txConfig, .transmitRequest, .irq);
  tx_datapath_model i_tx_datapath_model (.clk, .transmitRequest, .lag, .index1SendDone,
    .index2SendDone);
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] stat(input logic wk, input logic t2, input logic t1);
    return {24'h0, phySpeed10, phyLinkGood, wk, 1'b0, t2, t1, rxFifoOverflow, 1'b0};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    check_count++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask
  // Classic single cycle; the next request waits one idle cycle
  task automatic wb(input logic [3:0] idx, input logic we, input logic [7:0] d,
                    input logic [3:0] sel);
    int n;
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbSelI <= sel;
    wbAdrI <= {26'h0, idx, 2'h0};
    wbDatI <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAckO !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("unexpected at %0t: no acknowledge", $time);
    end
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d, 4'hF);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input logic [31:0] m);
    expQ.push_back({m, exp});
    wb(idx, 1'b0, 8'h00, 4'hF);
  endtask
  // One waits on software reset, zero on the transmit request
  task automatic waitLow(input logic which, input int lim);
    int n;
    n = 0;
    while ((which ? softResetActive : transmitRequest) === 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      $display("unexpected at %0t: level stuck high", $time);
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic wakePulse;
    wakeupEventIn <= 1'b1;
    repeat (2) @(posedge clk);
    wakeupEventIn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic end_of_test;
    // A read that never came back would otherwise go unnoticed
    if (expQ.size() != 0) begin
      errors++;
      $display("unexpected at %0t: %0d reads never answered", $time, expQ.size());
    end
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (wbAckO === 1'b1 && wbWeI === 1'b0) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("unexpected at %0t: read with no expectation", $time);
      end else begin
        ent = expQ.pop_front();
        check(wbDatO, ent[31:0], ent[63:32]);
      end
    end
  end
  initial begin
    #400us;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    lfsr = next_rand(lfsr);
    phyDuplexFull <= lfsr[0];
    phySpeed10 <= lfsr[1];
    phyLinkGood <= lfsr[2];
    rxFifoOverflow <= lfsr[4];
    lag <= lfsr[8:5];
    repeat (4) @(posedge clk);
    rd(4'h0, {28'h0, lfsr[0], 3'h0}, 32'hFFFFFF5F);
    rd(4'h1, stat(1'b0, 1'b0, 1'b0), 32'hFFFFFFEE);
    rd(4'h2, 32'h0, 32'hFFFFFF7F);
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    $display("test reset_values done");
    for (int c = 0; c < 3; c++) begin
      wr(4'h0, {3'h0, c[0], 1'b0, c[1:0], 1'b0});
      check({31'h0, forcedCollisionTest}, {31'h0, c[0]}, 32'h1);
      check({30'h0, loopbackSelect}, c, 32'h3);
      rd(4'h0, {27'h0, c[0], lfsr[0], c[1:0], 1'b0}, 32'hFFFFFF5F);
    end
    $display("test network_control done");
    lfsr = next_rand(lfsr);
    wr(4'h2, {1'b0, lfsr[5:0], 1'b0});
    check({26'h0, txConfig}, lfsr[5:0], 32'h3F);
    wb(4'h2, 1'b1, 8'h00, 4'hE);
    rd(4'h2, {25'h0, lfsr[5:0], 1'b0}, 32'hFFFFFF7F);
    wr(4'hE, 8'hFF);
    wr(4'h2, 8'h00);
    $display("test transmit_control done");
    wr(4'h4, 8'h02);
    wr(4'h2, 8'h01);
    rd(4'h2, 32'h1, 32'hFFFFFF7F);
    waitLow(1'b0, 100);
    check({31'h0, irq}, 32'h1, 32'h1);
    rd(4'h1, stat(1'b0, 1'b0, 1'b1), 32'hFFFFFFEE);
    rd(4'h1, stat(1'b0, 1'b0, 1'b0), 32'hFFFFFFEE);
    // Overflow high at reset release counts as a rising edge
    rd(4'h3, {28'h0, rxFifoOverflow, 3'h2}, 32'hFFFFFFFF);
    wr(4'h3, 8'h02);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, 32'h1);
    wr(4'h2, 8'h01);
    waitLow(1'b0, 100);
    check({31'h0, irq}, 32'h0, 32'h1);
    rd(4'h3, {28'h0, rxFifoOverflow, 3'h4}, 32'hFFFFFFFF);
    wr(4'h1, 8'h08);
    rd(4'h1, stat(1'b0, 1'b0, 1'b0), 32'hFFFFFFEE);
    wr(4'h3, 8'h04);
    $display("test transmit_flow done");
    wr(4'h0, 8'h40);
    wakePulse();
    rd(4'h1, stat(1'b1, 1'b0, 1'b0), 32'hFFFFFFEE);
    rd(4'h1, stat(1'b0, 1'b0, 1'b0), 32'hFFFFFFEE);
    wakePulse();
    wr(4'h0, 8'h00);
    rd(4'h1, stat(1'b0, 1'b0, 1'b0), 32'hFFFFFFEE);
    $display("test wakeup done");
    wr(4'h0, 8'h40);
    wakePulse();
    wr(4'h2, 8'h7E);
    wr(4'h0, 8'h53);
    check({31'h0, softResetActive}, 32'h1, 32'h1);
    waitLow(1'b1, 700);
    check({31'h0, wakeupEnable}, 32'h1, 32'h1);
    rd(4'h0, {25'h0, 1'b1, 2'h0, lfsr[0] ^ 1'b0, 3'h0} & 32'hFFFFFF4F | {28'h0, phyDuplexFull,
       3'h0}, 32'hFFFFFF5F);
    rd(4'h1, stat(1'b1, 1'b0, 1'b0), 32'hFFFFFFEE);
    rd(4'h2, 32'h0, 32'hFFFFFF7F);
    $display("test soft_reset done");
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule // mac_network_tx_control_tb
